// *** gpio_port.v ***
// eight-pin general purpose i/o port with an axi4-lite register slave
// assumes i_pin is asynchronous; sleep clamp and interrupt enables come from
// logic on i_ref_clk; the pad resolves level from out, enable and pull-up
//
// Summary of operation
// - output and direction registers read/write, input register read only.
// - global pull-up disable bit switches off pull-ups on all pins.
// - direction bit one makes pin output, zero makes it input.
// - output pin driven to its value bit regardless of pull-up disable.
// - input pin pulled up only if value bit one and disable clear.
// - all pins tri-stated during reset, asynchronously, without clock.
// - set and clear registers change single pins, others untouched.
// - input register shows synchronised pin level in either direction.
// - falling-edge capture then rising-edge capture forms the synchroniser.
// - external pin change visible after half to one and a half clocks.
// - written pin value readable one clock later; software waits one cycle.
// - sleep clamp grounds each pin's digital input path.
// - clamp skipped on pins with their external interrupt enabled.
// - clamp release on a high pin yields the edge flagging its interrupt.
// - pull-ups switched off while reset is held.
// - per-pin logic keeps other pins unaffected by any one pin's use.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "gpio_regs.vh"

module gpio_port (
    input  wire                      i_ref_clk,
    input  wire                      i_rst_n,
    // axi4-lite slave
    input  wire [`GPIO_ADDR_W-1:0]   i_axi_awaddr,
    input  wire                      i_axi_awvalid,
    output reg                       o_axi_awready,
    input  wire [31:0]               i_axi_wdata,
    input  wire [3:0]                i_axi_wstrb,
    input  wire                      i_axi_wvalid,
    output reg                       o_axi_wready,
    output reg  [1:0]                o_axi_bresp,
    output reg                       o_axi_bvalid,
    input  wire                      i_axi_bready,
    input  wire [`GPIO_ADDR_W-1:0]   i_axi_araddr,
    input  wire                      i_axi_arvalid,
    output reg                       o_axi_arready,
    output reg  [31:0]               o_axi_rdata,
    output reg  [1:0]                o_axi_rresp,
    output reg                       o_axi_rvalid,
    input  wire                      i_axi_rready,
    // sleep controller and interrupt enables
    input  wire                      i_sleep_clamp,
    input  wire [`GPIO_PIN_COUNT-1:0] i_ext_int_en,
    // pads
    input  wire [`GPIO_PIN_COUNT-1:0] i_pin,
    output reg  [`GPIO_PIN_COUNT-1:0] o_pin_out,
    output reg  [`GPIO_PIN_COUNT-1:0] o_pin_oe,
    output reg  [`GPIO_PIN_COUNT-1:0] o_pullup_en,
    output wire [`GPIO_PIN_COUNT-1:0] o_port_input_register
);

    // ==================================================================
    // state
    // o_pin_out is the output register and o_pin_oe the direction register
    reg                        global_pullup_disable;
    reg                        aw_hold;
    reg                        w_hold;
    reg [`GPIO_ADDR_W-1:0]     aw_addr;
    reg [7:0]                  w_data;
    reg                        w_lane0;

    wire [`GPIO_PIN_COUNT-1:0] port_output_register;
    wire [`GPIO_PIN_COUNT-1:0] port_direction_register;
    wire [`GPIO_PIN_COUNT-1:0] pin_digital_in;

    assign port_output_register    = o_pin_out;
    assign port_direction_register = o_pin_oe;

    // ==================================================================
    // write channel bookkeeping
    wire aw_take    = i_axi_awvalid & o_axi_awready;
    wire w_take     = i_axi_wvalid & o_axi_wready;
    wire write_fire = aw_hold & w_hold & ~o_axi_bvalid;

    reg next_aw_hold;
    reg next_w_hold;

    always @* begin
        next_aw_hold = aw_hold ? ~write_fire : aw_take;
        next_w_hold  = w_hold  ? ~write_fire : w_take;
    end

    // ==================================================================
    // register write decode; set/clear words touch only the one-bits
    reg [`GPIO_PIN_COUNT-1:0] next_port;
    reg [`GPIO_PIN_COUNT-1:0] next_dir;
    reg                       next_pud;
    reg                       write_known;

    always @* begin
        next_port   = port_output_register;
        next_dir    = port_direction_register;
        next_pud    = global_pullup_disable;
        write_known = 1'b1;
        case (aw_addr)
            `GPIO_OFS_OUTPUT:    write_known = 1'b1;
            `GPIO_OFS_DIRECTION: write_known = 1'b1;
            `GPIO_OFS_INPUT:     write_known = 1'b1;
            `GPIO_OFS_SPECIAL:   write_known = 1'b1;
            `GPIO_OFS_OUT_SET:   write_known = 1'b1;
            `GPIO_OFS_OUT_CLR:   write_known = 1'b1;
            `GPIO_OFS_DIR_SET:   write_known = 1'b1;
            `GPIO_OFS_DIR_CLR:   write_known = 1'b1;
            default:             write_known = 1'b0;
        endcase
        if (write_fire && w_lane0) begin
            case (aw_addr)
                `GPIO_OFS_OUTPUT:    next_port = w_data;
                `GPIO_OFS_DIRECTION: next_dir  = w_data;
                `GPIO_OFS_SPECIAL:   next_pud  = w_data[`GPIO_PUD_BIT];
                `GPIO_OFS_OUT_SET:   next_port = port_output_register | w_data;
                `GPIO_OFS_OUT_CLR:   next_port = port_output_register & ~w_data;
                `GPIO_OFS_DIR_SET:   next_dir  = port_direction_register | w_data;
                `GPIO_OFS_DIR_CLR:   next_dir  = port_direction_register & ~w_data;
                default:             next_port = port_output_register;
            endcase
        end
    end

    // ==================================================================
    // registers and pad controls; async reset tri-states and drops pull-ups
    // the pull-up flop is loaded from next values so it tracks the registers
    // in the same cycle rather than lagging one clock behind them
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin_out             <= `GPIO_RST_OUTPUT;
            o_pin_oe              <= `GPIO_RST_DIRECTION;
            o_pullup_en           <= {`GPIO_PIN_COUNT{1'b0}};
            global_pullup_disable <= `GPIO_RST_PUD;
        end else begin
            o_pin_out             <= next_port;
            o_pin_oe              <= next_dir;
            o_pullup_en           <= ~next_dir & next_port
                                     & {`GPIO_PIN_COUNT{~next_pud}};
            global_pullup_disable <= next_pud;
        end
    end

    // ==================================================================
    // axi write channels
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr       <= {`GPIO_ADDR_W{1'b0}};
            w_data        <= 8'h00;
            w_lane0       <= 1'b0;
            o_axi_awready <= 1'b0;
            o_axi_wready  <= 1'b0;
            o_axi_bvalid  <= 1'b0;
            o_axi_bresp   <= `GPIO_RESP_OKAY;
        end else begin
            aw_hold       <= next_aw_hold;
            w_hold        <= next_w_hold;
            o_axi_awready <= ~next_aw_hold;
            o_axi_wready  <= ~next_w_hold;
            if (aw_take) begin
                aw_addr <= i_axi_awaddr;
            end
            if (w_take) begin
                w_data  <= i_axi_wdata[7:0];
                w_lane0 <= i_axi_wstrb[0];
            end
            if (write_fire) begin
                o_axi_bvalid <= 1'b1;
                o_axi_bresp  <= write_known ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
            end else if (o_axi_bvalid && i_axi_bready) begin
                o_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==================================================================
    // axi read channel: one read in flight, answered the cycle after arready
    reg [31:0] read_word;
    reg        read_known;

    always @* begin
        read_word  = 32'h0000_0000;
        read_known = 1'b1;
        case (i_axi_araddr)
            `GPIO_OFS_OUTPUT:    read_word[7:0] = port_output_register;
            `GPIO_OFS_DIRECTION: read_word[7:0] = port_direction_register;
            `GPIO_OFS_INPUT:     read_word[7:0] = o_port_input_register;
            `GPIO_OFS_SPECIAL:   read_word[`GPIO_PUD_BIT] = global_pullup_disable;
            `GPIO_OFS_OUT_SET:   read_known = 1'b1;
            `GPIO_OFS_OUT_CLR:   read_known = 1'b1;
            `GPIO_OFS_DIR_SET:   read_known = 1'b1;
            `GPIO_OFS_DIR_CLR:   read_known = 1'b1;
            default:             read_known = 1'b0;
        endcase
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_axi_arready <= 1'b0;
            o_axi_rvalid  <= 1'b0;
            o_axi_rdata   <= 32'h0000_0000;
            o_axi_rresp   <= `GPIO_RESP_OKAY;
        end else begin
            if (i_axi_arvalid && o_axi_arready) begin
                o_axi_arready <= 1'b0;
                o_axi_rvalid  <= 1'b1;
                o_axi_rdata   <= read_word;
                o_axi_rresp   <= read_known ? `GPIO_RESP_OKAY : `GPIO_RESP_SLVERR;
            end else if (o_axi_rvalid) begin
                if (i_axi_rready) begin
                    o_axi_rvalid  <= 1'b0;
                    o_axi_arready <= 1'b1;
                end
            end else begin
                o_axi_arready <= 1'b1;
            end
        end
    end

    // ==================================================================
    // input path: clamp ahead of the synchroniser, one slice per pin
    // the clamp gates the raw level before the first flop, so releasing it on a
    // high pin shows as a rising edge to interrupt logic watching the input
    genvar gi;
    generate
        for (gi = 0; gi < `GPIO_PIN_COUNT; gi = gi + 1) begin : g_pin
            assign pin_digital_in[gi] = i_pin[gi]
                                        & ~(i_sleep_clamp & ~i_ext_int_en[gi]);
            gpio_sync u_sync (
                .i_ref_clk (i_ref_clk),
                .i_rst_n   (i_rst_n),
                .i_level   (pin_digital_in[gi]),
                .o_sampled (o_port_input_register[gi])
            );
        end
    endgenerate

endmodule

// *** gpio_regs.vh ***
// register map, field positions, reset values and bus codes of the gpio port
// assumes a 32-bit axi4-lite register bus with word-aligned registers
`ifndef GPIO_REGS_VH
`define GPIO_REGS_VH

// ==================================================================
// register byte offsets
`define GPIO_OFS_OUTPUT      8'h00
`define GPIO_OFS_DIRECTION   8'h04
`define GPIO_OFS_INPUT       8'h08
`define GPIO_OFS_SPECIAL     8'h0c
`define GPIO_OFS_OUT_SET     8'h10
`define GPIO_OFS_OUT_CLR     8'h14
`define GPIO_OFS_DIR_SET     8'h18
`define GPIO_OFS_DIR_CLR     8'h1c

// ==================================================================
// widths, fields and reset values
`define GPIO_PIN_COUNT       8
`define GPIO_ADDR_W          8
`define GPIO_PUD_BIT         0
`define GPIO_RST_OUTPUT      8'h00
`define GPIO_RST_DIRECTION   8'h00
`define GPIO_RST_PUD         1'b0

// ==================================================================
// bus response codes
`define GPIO_RESP_OKAY       2'b00
`define GPIO_RESP_SLVERR     2'b10

// ==================================================================
// timing: a written value reaches the input register after this many clocks
`define GPIO_READBACK_CYCLES 1

`endif

// *** gpio_sync.v ***
// one-pin input synchroniser: falling-edge capture stage, then rising-edge stage
// assumes the pin level is asynchronous to i_ref_clk and already clamp-gated
`timescale 1ns/1ps

module gpio_sync (
    input  wire i_ref_clk,
    input  wire i_rst_n,
    input  wire i_level,
    output reg  o_sampled
);

    reg stage_low;

    // ==================================================================
    // first stage closes on the falling edge, like a latch open while high
    always @(negedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage_low <= 1'b0;
        end else begin
            stage_low <= i_level;
        end
    end

    // ==================================================================
    // second stage: only reader of the first stage, gives half to 1.5 clocks
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sampled <= 1'b0;
        end else begin
            o_sampled <= stage_low;
        end
    end

endmodule

// *** gpio_port_properties.sv ***
// concurrent checks on the pins and the axi4-lite slave of the gpio port
// assumes only the ports of gpio_port; bound by the statement at the foot
`timescale 1ns/1ps
module gpio_port_properties (
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    input wire logic        i_axi_awvalid,
    input wire logic        o_axi_awready,
    input wire logic        i_axi_wvalid,
    input wire logic        o_axi_wready,
    input wire logic [1:0]  o_axi_bresp,
    input wire logic        o_axi_bvalid,
    input wire logic        i_axi_bready,
    input wire logic        i_axi_arvalid,
    input wire logic        o_axi_arready,
    input wire logic [31:0] o_axi_rdata,
    input wire logic        o_axi_rvalid,
    input wire logic        i_axi_rready,
    input wire logic        i_sleep_clamp,
    input wire logic [7:0]  i_ext_int_en,
    input wire logic [7:0]  i_pin,
    input wire logic [7:0]  o_pin_out,
    input wire logic [7:0]  o_pin_oe,
    input wire logic [7:0]  o_pullup_en,
    input wire logic [7:0]  o_port_input_register
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========================================================
    // falling-edge reference of the clamped pin level
    logic [7:0] capt;
    always @(negedge i_ref_clk or negedge i_rst_n)
        if (!i_rst_n)
            capt <= 8'h00;
        else
            capt <= i_pin & ~({8{i_sleep_clamp}} & ~i_ext_int_en);
    // ==========================================================
    // properties
    chk_reset_tristate: assert property (disable iff (1'b0)
        !i_rst_n |-> o_pin_oe == 8'h00 && o_pullup_en == 8'h00)
        else $error("pins not released in reset");
    chk_pullup_input: assert property ((o_pullup_en & o_pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    chk_pullup_value: assert property ((o_pullup_en & ~o_pin_out) == 8'h00)
        else $error("pull-up with value bit low");
    chk_input_sync: assert property (o_port_input_register == $past(capt))
        else $error("input register not the half-cycle capture");
    chk_out_by_write: assert property (!$stable(o_pin_out) |-> o_axi_bvalid)
        else $error("drive value changed without a write");
    chk_write_answer: assert property (i_axi_awvalid && o_axi_awready && i_axi_wvalid
        && o_axi_wready |-> ##2 o_axi_bvalid)
        else $error("write response late");
    chk_bresp_hold: assert property (o_axi_bvalid && !i_axi_bready
        |=> o_axi_bvalid && $stable(o_axi_bresp))
        else $error("write response dropped");
    chk_read_answer: assert property (i_axi_arvalid && o_axi_arready
        |=> o_axi_rvalid && o_axi_rdata[31:8] == 24'h000000)
        else $error("read answer late or wide");
    chk_rdata_hold: assert property (o_axi_rvalid && !i_axi_rready
        |=> o_axi_rvalid && $stable(o_axi_rdata))
        else $error("read data dropped");
endmodule

bind gpio_port gpio_port_properties gpio_port_properties_inst (
    .i_ref_clk             (i_ref_clk),
    .i_rst_n               (i_rst_n),
    .i_axi_awvalid         (i_axi_awvalid),
    .o_axi_awready         (o_axi_awready),
    .i_axi_wvalid          (i_axi_wvalid),
    .o_axi_wready          (o_axi_wready),
    .o_axi_bresp           (o_axi_bresp),
    .o_axi_bvalid          (o_axi_bvalid),
    .i_axi_bready          (i_axi_bready),
    .i_axi_arvalid         (i_axi_arvalid),
    .o_axi_arready         (o_axi_arready),
    .o_axi_rdata           (o_axi_rdata),
    .o_axi_rvalid          (o_axi_rvalid),
    .i_axi_rready          (i_axi_rready),
    .i_sleep_clamp         (i_sleep_clamp),
    .i_ext_int_en          (i_ext_int_en),
    .i_pin                 (i_pin),
    .o_pin_out             (o_pin_out),
    .o_pin_oe              (o_pin_oe),
    .o_pullup_en           (o_pullup_en),
    .o_port_input_register (o_port_input_register)
);

// *** gpio_pad_model.sv ***
// board side of the eight pads: device driver, pull-up and external driver
// assumes one clock to move the level of an undriven, unpulled pad
`timescale 1ns/1ps
module gpio_pad_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_pu,
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    output wire logic [7:0] o_level
);
    // a floating pad toggles so a stale level never reads as valid
    logic [7:0] last = 8'h00;
    always @(posedge i_clk)
        last <= o_level;
    // defined level from the pull-up wherever nothing drives
    assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
                   | (~i_oe & ~i_ext_en & (i_pu | ~last));
endmodule

// *** gpio_port_tb.sv ***
// self-checking bench of the gpio port through its axi4-lite slave
// assumes gpio_port, gpio_pad_model and the register header
`timescale 1ns/1ps
`include "gpio_regs.vh"
module gpio_port_tb;
    // reset starts high for an instant so the design sees its falling edge at time zero
    logic        ref_clk = 0, rst_n = 1, clamp = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0, ie = 0, ext_en = 8'hff, ext_val = 8'ha5;
    logic [31:0] wdata = 0;
    logic [3:0]  strb = 4'hf;
    wire         awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  pin, pout, oe, pu, inreg;
    int          err_total = 0, checks_done = 0, cycles = 0;
    gpio_port gpio_port_inst (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_axi_awaddr(awaddr),
        .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_wdata(wdata),
        .i_axi_wstrb(strb), .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
        .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
        .i_axi_arvalid(arvalid), .o_axi_arready(arready), .o_axi_rdata(rdata),
        .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
        .i_sleep_clamp(clamp), .i_ext_int_en(ie), .i_pin(pin), .o_pin_out(pout),
        .o_pin_oe(oe), .o_pullup_en(pu), .o_port_input_register(inreg));
    gpio_pad_model gpio_pad_model_inst (.i_clk(ref_clk), .i_oe(oe), .i_out(pout), .i_pu(pu),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pin));
    // ==========================================================
    // clock, watchdog and tasks
    initial forever #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            test_done;
        end
    end
    task test_done;
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            err_total++;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // bready trails bvalid by a cycle so the response has to stand
        do begin
            @(posedge ref_clk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b1;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask
    task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        // rready trails rvalid by a cycle so the read data has to stand
        do begin
            @(posedge ref_clk);
            if (arready && arvalid) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b1;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        chk("rdata", rdata, ed);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask
    task pins(input [7:0] o, input [7:0] d, input [7:0] p);
        chk("pin_out", {24'h0, pout}, {24'h0, o});
        chk("pin_oe", {24'h0, oe}, {24'h0, d});
        chk("pullup", {24'h0, pu}, {24'h0, p});
    endtask
    task side(input [7:0] en, input [7:0] val, input [7:0] ien, input cl);
        @(posedge ref_clk);
        ext_en <= en;
        ext_val <= val;
        ie <= ien;
        clamp <= cl;
        repeat (3) @(posedge ref_clk);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        pins(8'h00, 8'h00, 8'h00);
        rst_n <= 1'b1;
        rd(`GPIO_OFS_OUTPUT, 0, `GPIO_RESP_OKAY);
        rd(`GPIO_OFS_DIRECTION, 0, `GPIO_RESP_OKAY);
        rd(`GPIO_OFS_SPECIAL, 0, `GPIO_RESP_OKAY);
        rd(`GPIO_OFS_INPUT, 8'ha5, `GPIO_RESP_OKAY);
        wr(`GPIO_OFS_OUTPUT, 8'hff, `GPIO_RESP_OKAY);
        pins(8'hff, 8'h00, 8'hff);
        wr(`GPIO_OFS_SPECIAL, 1, `GPIO_RESP_OKAY);
        pins(8'hff, 8'h00, 8'h00);
        wr(`GPIO_OFS_SPECIAL, 0, `GPIO_RESP_OKAY);
        wr(`GPIO_OFS_DIRECTION, 8'h0f, `GPIO_RESP_OKAY);
        pins(8'hff, 8'h0f, 8'hf0);
        side(8'hf0, 8'ha5, 8'h00, 1'b0);
        rd(`GPIO_OFS_INPUT, 8'haf, `GPIO_RESP_OKAY);
        wr(`GPIO_OFS_SPECIAL, 1, `GPIO_RESP_OKAY);
        pins(8'hff, 8'h0f, 8'h00);
        side(8'h00, 8'h00, 8'h00, 1'b0);
        wr(`GPIO_OFS_SPECIAL, 0, `GPIO_RESP_OKAY);
        rd(`GPIO_OFS_INPUT, 8'hff, `GPIO_RESP_OKAY);
        wr(`GPIO_OFS_OUT_CLR, 8'h01, `GPIO_RESP_OKAY);
        // driven pin 0 fell at the fire edge; one clock later the input bit follows
        chk("inreg", {24'h0, inreg}, 32'h0000_00fe);
        pins(8'hfe, 8'h0f, 8'hf0);
        wr(`GPIO_OFS_DIR_CLR, 8'h02, `GPIO_RESP_OKAY);
        pins(8'hfe, 8'h0d, 8'hf2);
        wr(`GPIO_OFS_DIR_SET, 8'h10, `GPIO_RESP_OKAY);
        pins(8'hfe, 8'h1d, 8'he2);
        rd(`GPIO_OFS_OUT_SET, 0, `GPIO_RESP_OKAY);
        rd(`GPIO_OFS_INPUT, 8'hfe, `GPIO_RESP_OKAY);
        side(8'h00, 8'h00, 8'h02, 1'b1);
        rd(`GPIO_OFS_INPUT, 8'h02, `GPIO_RESP_OKAY);
        side(8'h00, 8'h00, 8'h02, 1'b0);
        rd(`GPIO_OFS_INPUT, 8'hfe, `GPIO_RESP_OKAY);
        wr(8'h20, 8'hff, `GPIO_RESP_SLVERR);
        rd(8'h20, 0, `GPIO_RESP_SLVERR);
        // a write with its low byte lane off must leave the output register alone
        strb <= 4'h0;
        wr(`GPIO_OFS_OUTPUT, 8'h00, `GPIO_RESP_OKAY);
        strb <= 4'hf;
        wr(`GPIO_OFS_INPUT, 8'h00, `GPIO_RESP_OKAY);
        rd(`GPIO_OFS_OUTPUT, 8'hfe, `GPIO_RESP_OKAY);
        rd(`GPIO_OFS_DIRECTION, 8'h1d, `GPIO_RESP_OKAY);
        // second reset in mid-run must float the pads without a clock edge
        @(posedge ref_clk);
        rst_n <= 1'b0;
        #1;
        pins(8'h00, 8'h00, 8'h00);
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`GPIO_OFS_DIRECTION, 0, `GPIO_RESP_OKAY);
        test_done;
    end
endmodule
